// ---- design/cawd_top.sv ----
// Counter array with module 2 watchdog, control/status and mode registers.
// Assumes the CPU writes and reads over a byte bus on clk; idle and event
// inputs come from same-clock logic, ext_clk_pin is asynchronous.
// How it works
// RQ1: Software disables, configures, enables, then updates.
// RQ2: Clock select and idle bit frozen while enabled.
// RQ3: Watchdog runs when enable or lock set.
// RQ4: Lock keeps watchdog on until reset.
// RQ5: Without lock, clearing enable disables it.
// RQ6: Every reset leaves watchdog enabled.
// RQ7: Reset selects clk/12, low and offset zero.
// RQ8: Reset defaults time out after 3072 cycles.
// RQ9: Idle suspend bit halts counting in idle.
// RQ10: Bit 7 set on counter wrap.
// RQ11: Bit 6 starts or stops the counter.
// RQ12: Module flags set on match or capture.
// RQ13: Bits 5 to 3 read zero.
// RQ14: System clock reset divider is eight.
// RQ15: Update write loads high plus offset.
// RQ16: Low overflow with update match resets.
// RQ17: Writing 1 to module 2 flag resets.
// RQ18: Watchdog forces counter running.
// RQ19: Software writes 0 clear, 1 set flags.
module cawd_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register bus
    input wire cawd_pkg::cawd_req_t req,
    output logic [7:0] rdata,
    // System status and events
    input wire logic cpu_idle,
    input wire cawd_pkg::cawd_evt_t evt,
    input wire logic ext_clk_pin,
    // Outputs
    output logic irq,
    output logic wdt_reset,
    output logic [2:0] osc_div,
    output logic [15:0] count
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [7:0] offs_q;
    logic [7:0] offs_d;
    logic [7:0] updt_q;
    logic [7:0] updt_d;
    logic [7:0] msel_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic wdt_reset_q;
    logic [2:0] osc_div_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic tick;
    logic wd_on;
    logic run;
    logic step;
    logic low_ovf;
    logic cnt_wrap;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_cntl;
    logic wr_cnth;
    logic wr_offs;
    logic wr_updt;
    logic wr_msel;
    logic force_rst;
    logic wd_hit;
    logic [7:0] ctrl_rd;
    logic [2:0] flag_set;
    logic [2:0] flag_wr;

    // Address decode
    assign wr_ctrl = req.wr && (req.addr == cawd_pkg::CTRL_ADDR);
    assign wr_mode = req.wr && (req.addr == cawd_pkg::MODE_ADDR);
    assign wr_cntl = req.wr && (req.addr == cawd_pkg::CNTL_ADDR);
    assign wr_cnth = req.wr && (req.addr == cawd_pkg::CNTH_ADDR);
    assign wr_offs = req.wr && (req.addr == cawd_pkg::OFFS_ADDR);
    assign wr_updt = req.wr && (req.addr == cawd_pkg::UPDT_ADDR);
    assign wr_msel = req.wr && (req.addr == cawd_pkg::MSEL_ADDR);

    // RQ3: watchdog on
    assign wd_on = mode_q[cawd_pkg::MODE_WDEN] | mode_q[cawd_pkg::MODE_LOCK];

    // External counter clock, two-stage sync then edge detect
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_clk_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // Counter clock tick
    cawd_tick u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .sel(mode_q[cawd_pkg::MODE_CSEL_LO +: 3]),
        .ext_tick(ext_s2_q & ~ext_s3_q),
        .tick(tick)
    );

    // RQ18: watchdog forces run
    // RQ9: idle suspend gate
    assign run = (ctrl_q[cawd_pkg::CTRL_RUN] | wd_on) &
                 ~(cpu_idle & mode_q[cawd_pkg::MODE_IDLE]);
    assign step = run & tick;
    assign low_ovf = step & (cnt_q[7:0] == 8'hff);
    // RQ10: full counter wrap
    assign cnt_wrap = step & (cnt_q == 16'hffff);

    // RQ16: low overflow on match
    // RQ8: defaults give 256 ticks
    assign wd_hit = wd_on & low_ovf & (updt_q == cnt_q[15:8]);
    // RQ17: forced reset write
    assign force_rst = wd_on & wr_ctrl & req.wdata[cawd_pkg::CTRL_M2];

    // Counter next value; byte writes blocked while the watchdog runs
    always_comb begin
        cnt_d = step ? cnt_q + 16'h0001 : cnt_q;
        if (!wd_on && wr_cntl) begin
            cnt_d[7:0] = req.wdata;
        end
        if (!wd_on && wr_cnth) begin
            cnt_d[15:8] = req.wdata;
        end
    end

    // RQ4: lock holds enable
    // RQ5: clear enable disables
    // RQ2: freeze select and idle
    always_comb begin
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d = req.wdata & cawd_pkg::MODE_USED;
            if (wd_on) begin
                mode_d[cawd_pkg::MODE_IDLE] = mode_q[cawd_pkg::MODE_IDLE];
                mode_d[cawd_pkg::MODE_CSEL_LO +: 3] =
                    mode_q[cawd_pkg::MODE_CSEL_LO +: 3];
            end
            if (mode_q[cawd_pkg::MODE_LOCK]) begin
                mode_d[cawd_pkg::MODE_LOCK] = 1'b1;
                mode_d[cawd_pkg::MODE_WDEN] = mode_q[cawd_pkg::MODE_WDEN];
            end
        end
    end

    // Flag events and software writes
    assign flag_set = {evt.m2, evt.m1, evt.m0};
    assign flag_wr = req.wdata[cawd_pkg::CTRL_M2:cawd_pkg::CTRL_M0];

    // RQ19: software writes flags
    // RQ12: hardware set wins
    // RQ13: unused bits zero
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = req.wdata & cawd_pkg::CTRL_USED;
            if (force_rst) begin
                ctrl_d[cawd_pkg::CTRL_M2] = ctrl_q[cawd_pkg::CTRL_M2];
            end
        end
        ctrl_d[cawd_pkg::CTRL_M2:cawd_pkg::CTRL_M0] =
            ctrl_d[cawd_pkg::CTRL_M2:cawd_pkg::CTRL_M0] | flag_set;
        // RQ10: overflow flag set
        if (cnt_wrap) begin
            ctrl_d[cawd_pkg::CTRL_OVF] = 1'b1;
        end
    end

    // RQ15: update load
    assign updt_d = wr_updt ? cnt_q[15:8] + offs_q : updt_q;
    assign offs_d = wr_offs ? req.wdata : offs_q;

    // Read mux; run bit shows software setting only
    assign ctrl_rd = ctrl_q & cawd_pkg::CTRL_USED;
    always_comb begin
        case (req.addr)
            cawd_pkg::CTRL_ADDR: rdata_d = ctrl_rd;
            cawd_pkg::MODE_ADDR: rdata_d = mode_q;
            cawd_pkg::CNTL_ADDR: rdata_d = cnt_q[7:0];
            cawd_pkg::CNTH_ADDR: rdata_d = cnt_q[15:8];
            cawd_pkg::OFFS_ADDR: rdata_d = offs_q;
            cawd_pkg::UPDT_ADDR: rdata_d = updt_q;
            cawd_pkg::MSEL_ADDR: rdata_d = msel_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // RQ6: reset enables watchdog
    // RQ7: reset defaults
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_q <= cawd_pkg::CTRL_RESET;
            mode_q <= cawd_pkg::MODE_RESET;
            cnt_q <= 16'h0000;
            offs_q <= cawd_pkg::BYTE_RESET;
            updt_q <= cawd_pkg::BYTE_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            offs_q <= offs_d;
            updt_q <= updt_d;
        end
    end

    // Module 2 mode register, write blocked while watchdog runs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            msel_q <= cawd_pkg::BYTE_RESET;
        end else if (wr_msel && !wd_on) begin
            msel_q <= req.wdata;
        end
    end

    // Read data and watchdog reset pulse
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
            wdt_reset_q <= 1'b0;
        end else begin
            rdata_q <= req.rd ? rdata_d : 8'h00;
            wdt_reset_q <= wd_hit | force_rst;
        end
    end

    // RQ14: oscillator divide at reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            osc_div_q <= 3'(cawd_pkg::OSC_DIV_RESET - 1);
        end else begin
            osc_div_q <= osc_div_q;
        end
    end

    // Interrupt request from the overflow flag when enabled, or from any module flag
    assign irq = (ctrl_q[cawd_pkg::CTRL_OVF] & mode_q[cawd_pkg::MODE_OVFIE])
                 | (|ctrl_q[cawd_pkg::CTRL_M2:cawd_pkg::CTRL_M0]);
    assign rdata = rdata_q;
    assign wdt_reset = wdt_reset_q;
    assign osc_div = osc_div_q;
    assign count = cnt_q;
endmodule

// ---- design/cawd_pkg.sv ----
// Constants and carrier types for the counter array watchdog block.
// Assumes an 8-bit special function register bus on the system clock.
package cawd_pkg;
    // Register addresses
    localparam logic [7:0] CTRL_ADDR = 8'hd8;  // control and status
    localparam logic [7:0] MODE_ADDR = 8'hd9;  // counter mode register
    localparam logic [7:0] CNTL_ADDR = 8'he9;  // counter low byte
    localparam logic [7:0] CNTH_ADDR = 8'hf9;  // counter high byte
    localparam logic [7:0] OFFS_ADDR = 8'hed;  // watchdog offset byte
    localparam logic [7:0] UPDT_ADDR = 8'hfd;  // watchdog update byte
    localparam logic [7:0] MSEL_ADDR = 8'hdc;  // module 2 mode register

    // Control register fields
    localparam int CTRL_OVF = 7;
    localparam int CTRL_RUN = 6;
    localparam int CTRL_M2 = 2;
    localparam int CTRL_M1 = 1;
    localparam int CTRL_M0 = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_USED = 8'hc7;

    // Mode register fields
    localparam int MODE_IDLE = 7;
    localparam int MODE_WDEN = 6;
    localparam int MODE_LOCK = 5;
    localparam int MODE_CSEL_LO = 1;
    localparam int MODE_OVFIE = 0;
    localparam logic [7:0] MODE_RESET = 8'h40;  // watchdog on, clk/12
    localparam logic [7:0] MODE_USED = 8'hef;

    // Counter clock selections
    localparam logic [2:0] CSEL_DIV12 = 3'h0;
    localparam logic [2:0] CSEL_DIV4 = 3'h1;
    localparam logic [2:0] CSEL_EXT = 3'h2;
    localparam logic [2:0] CSEL_SYS = 3'h4;

    // Divider counts and reset byte values
    localparam int DIV12 = 12;
    localparam int DIV4 = 4;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int OSC_DIV_RESET = 8;

    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cawd_req_t;

    // Module event inputs from the capture/compare modules
    typedef struct packed {
        logic m2;
        logic m1;
        logic m0;
    } cawd_evt_t;
endpackage

// ---- design/cawd_tick.sv ----
// Counter clock tick generator for the counter array.
// Assumes ext_tick is already synchronised to clk.
module cawd_tick #(
    parameter int DIV_A = cawd_pkg::DIV12,
    parameter int DIV_B = cawd_pkg::DIV4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Selection
    input wire logic [2:0] sel,
    input wire logic ext_tick,
    // Tick out
    output logic tick
);
    logic [3:0] div_q;
    logic [3:0] div_d;
    logic [3:0] limit;
    logic wrap;

    // Divider terminal count from selection
    assign limit = (sel == cawd_pkg::CSEL_DIV4) ? 4'(DIV_B - 1) :
                   4'(DIV_A - 1);
    assign wrap = (div_q >= limit);
    assign div_d = wrap ? 4'h0 : div_q + 4'h1;

    // Free running prescaler
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_d;
        end
    end

    // Tick selection
    always_comb begin
        case (sel)
            cawd_pkg::CSEL_DIV12: tick = wrap;
            cawd_pkg::CSEL_DIV4: tick = wrap;
            cawd_pkg::CSEL_EXT: tick = ext_tick;
            cawd_pkg::CSEL_SYS: tick = 1'b1;
            default: tick = wrap;
        endcase
    end
endmodule

// ---- sim/cawd_top_asserts.sv ----
// Port checker for cawd_top, bound at the foot of this file.
// Assumes one clock; shadows mode and offset writes locally.
module cawd_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus and events
    input wire cawd_pkg::cawd_req_t req,
    input wire logic [7:0] rdata,
    input wire logic cpu_idle,
    input wire cawd_pkg::cawd_evt_t evt,
    input wire logic ext_clk_pin,
    // Outputs
    input wire logic irq,
    input wire logic wdt_reset,
    input wire logic [2:0] osc_div,
    input wire logic [15:0] count
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic on_q, lock_q;
    logic [7:0] offs_q;
    // Decoded requests
    wire logic ctl_w = req.wr && req.addr == cawd_pkg::CTRL_ADDR;
    wire logic ctl_r = req.rd && req.addr == cawd_pkg::CTRL_ADDR;
    wire logic md_w = req.wr && req.addr == cawd_pkg::MODE_ADDR;
    wire logic md_r = req.rd && req.addr == cawd_pkg::MODE_ADDR;
    wire logic up_w = req.wr && req.addr == cawd_pkg::UPDT_ADDR;
    wire logic up_r = req.rd && req.addr == cawd_pkg::UPDT_ADDR;
    wire logic of_w = req.wr && req.addr == cawd_pkg::OFFS_ADDR;
    wire logic [7:0] hi = count[15:8];
    wire logic run_w = req.wdata[6];
    // Shadow of watchdog enable, lock and offset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            on_q <= 1'b1;
            lock_q <= 1'b0;
            offs_q <= 8'h00;
        end else begin
            if (md_w) on_q <= lock_q | req.wdata[6] | req.wdata[5];
            if (md_w) lock_q <= lock_q | req.wdata[5];
            if (of_w) offs_q <= req.wdata;
        end
    end
    sequence s_upd;
        up_w ##1 up_r;
    endsequence
    sequence s_ctl;
        ctl_w ##1 ctl_r;
    endsequence
    property p_upd;
        s_upd |=> rdata == 8'($past(hi, 2) + $past(offs_q, 2));
    endproperty
    property p_div;
        $rose(reset_n) |-> osc_div == 3'h7;
    endproperty
    property p_cnt;
        $rose(reset_n) |-> count == 16'h0000;
    endproperty
    property p_zero;
        ctl_r |=> rdata[5:3] == 3'h0;
    endproperty
    property p_force;
        ctl_w && req.wdata[2] && on_q |=> wdt_reset;
    endproperty
    property p_evt;
        (evt.m0 || evt.m1 || evt.m2) |=> irq;
    endproperty
    property p_run;
        s_ctl |=> rdata[6] == $past(run_w, 2);
    endproperty
    property p_lock;
        lock_q && md_w ##1 md_r |=> rdata[6:5] == 2'h3;
    endproperty
    a_upd: assert property (p_upd) else $error("update load");
    a_div: assert property (p_div) else $error("reset divide");
    a_cnt: assert property (p_cnt) else $error("reset count");
    a_zero: assert property (p_zero) else $error("unused bits");
    a_force: assert property (p_force) else $error("no forced reset");
    a_evt: assert property (p_evt) else $error("event flag");
    a_run: assert property (p_run) else $error("run bit");
    a_lock: assert property (p_lock) else $error("lock cleared");
endmodule
bind cawd_top cawd_top_asserts i_chk (
    .clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
    .cpu_idle(cpu_idle), .evt(evt), .ext_clk_pin(ext_clk_pin),
    .irq(irq), .wdt_reset(wdt_reset), .osc_div(osc_div), .count(count)
);

// ---- sim/cawd_cpu.sv ----
// CPU core model driving the register bus of cawd_top.
// Assumes calls start just after a rising clk edge.
module cawd_cpu (
    // Clock
    input wire logic clk,
    // Register bus
    output cawd_pkg::cawd_req_t req,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial req = '0;
    // One bus cycle; strobes stay until the next call
    task automatic xfer(input logic w, r, input logic [7:0] a, d);
        req = '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        xfer(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        xfer(1'b0, 1'b1, a, 8'h00);
        d = rdata;
    endtask
    task automatic idle();
        xfer(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic setup(input logic [2:0] cs, input logic [7:0] off,
                         input logic idl);
        wr(cawd_pkg::MODE_ADDR, 8'h00);
        wr(cawd_pkg::MODE_ADDR, {4'h0, cs, 1'b0});
        wr(cawd_pkg::OFFS_ADDR, off);
        wr(cawd_pkg::MODE_ADDR, {idl, 3'h0, cs, 1'b0});
        wr(cawd_pkg::MODE_ADDR, {idl, 3'h4, cs, 1'b0});
        wr(cawd_pkg::UPDT_ADDR, 8'h00);
        idle();
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for cawd_top with a CPU bus model.
// Assumes the checker is bound in by its own file.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset_n, cpu_idle, ext_clk_pin, irq, wdt_reset;
    cawd_pkg::cawd_req_t req;
    cawd_pkg::cawd_evt_t evt;
    logic [7:0] rdata, v;
    logic [2:0] osc_div;
    logic [15:0] count;
    int fail_count, checked, n;
    cawd_top i_dut (.clk(clk), .reset_n(reset_n), .req(req),
        .rdata(rdata), .cpu_idle(cpu_idle), .evt(evt),
        .ext_clk_pin(ext_clk_pin), .irq(irq), .wdt_reset(wdt_reset),
        .osc_div(osc_div), .count(count));
    cawd_cpu i_cpu (.clk(clk), .req(req), .rdata(rdata));
    // Clocks
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        ext_clk_pin = 1'b0;
        forever #23 ext_clk_pin = ~ext_clk_pin;
    end
    task automatic chk(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
    endtask
    // Bounded wait for a watchdog reset pulse
    task automatic wait_wd(input int lim);
        n = 0;
        while (wdt_reset !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= lim) begin
            fail_count++;
            complete_run();
        end
    endtask
    task automatic t_defaults();
        i_cpu.rd(cawd_pkg::CTRL_ADDR, v);
        chk(v, 8'h00);
        i_cpu.rd(cawd_pkg::MODE_ADDR, v);
        chk(v, 8'h40);
        i_cpu.rd(cawd_pkg::OFFS_ADDR, v);
        chk(v, 8'h00);
        i_cpu.idle();
        chk(osc_div, 3'h7);
        wait_wd(4000);
        chk(n >= 3060 && n <= 256 * cawd_pkg::DIV12 + 12, 1'b1);
    endtask
    task automatic t_force();
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h04);
        chk(wdt_reset, 1'b1);
        i_cpu.rd(cawd_pkg::CTRL_ADDR, v);
        chk(v, 8'h00);
    endtask
    task automatic t_config();
        logic [15:0] c;
        i_cpu.setup(cawd_pkg::CSEL_SYS, 8'h02, 1'b1);
        i_cpu.wr(cawd_pkg::MODE_ADDR, 8'h42);
        i_cpu.rd(cawd_pkg::MODE_ADDR, v);
        chk(v, 8'hc8);
        i_cpu.wr(cawd_pkg::UPDT_ADDR, 8'h00);
        i_cpu.rd(cawd_pkg::UPDT_ADDR, v);
        cpu_idle = 1'b1;
        i_cpu.idle();
        c = count;
        repeat (600) @(posedge clk);
        #1;
        chk(count, c);
        cpu_idle = 1'b0;
        wait_wd(800);
        chk(n <= 3 * 256 + 2, 1'b1);
    endtask
    task automatic t_lock();
        i_cpu.wr(cawd_pkg::MODE_ADDR, 8'h60);
        i_cpu.wr(cawd_pkg::MODE_ADDR, 8'h00);
        i_cpu.rd(cawd_pkg::MODE_ADDR, v);
        chk(v[6:5], 2'h3);
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h04);
        chk(wdt_reset, 1'b1);
        i_cpu.idle();
        do_reset();
        i_cpu.rd(cawd_pkg::MODE_ADDR, v);
        chk(v, 8'h40);
    endtask
    task automatic t_flags();
        logic [15:0] c;
        i_cpu.wr(cawd_pkg::MODE_ADDR, 8'h00);
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h04);
        chk(wdt_reset, 1'b0);
        i_cpu.rd(cawd_pkg::CTRL_ADDR, v);
        chk(v, 8'h04);
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h00);
        i_cpu.idle();
        for (int i = 0; i < 3; i++) begin
            evt = 3'h1 << i;
            @(posedge clk);
            #1;
        end
        evt = 3'h0;
        chk(irq, 1'b1);
        i_cpu.rd(cawd_pkg::CTRL_ADDR, v);
        chk(v, 8'h07);
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'hff);
        i_cpu.rd(cawd_pkg::CTRL_ADDR, v);
        chk(v, 8'hc7);
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h00);
        i_cpu.rd(cawd_pkg::CTRL_ADDR, v);
        chk(v, 8'h00);
        c = count;
        repeat (30) i_cpu.idle();
        chk(count, c);
    endtask
    task automatic t_wrap();
        i_cpu.wr(cawd_pkg::CNTL_ADDR, 8'hfe);
        i_cpu.wr(cawd_pkg::CNTH_ADDR, 8'hff);
        i_cpu.wr(cawd_pkg::MODE_ADDR, 8'h09);
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h40);
        repeat (3) i_cpu.idle();
        i_cpu.rd(cawd_pkg::CTRL_ADDR, v);
        chk(v, 8'hc0);
        chk(irq, 1'b1);
        i_cpu.idle();
    endtask
    // Divide by four and external edge selections, watchdog off
    task automatic t_clksel();
        logic [15:0] c;
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h00);
        i_cpu.wr(cawd_pkg::MODE_ADDR, 8'h02);
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h40);
        cpu_idle = 1'b1;
        i_cpu.idle();
        c = count;
        repeat (40) @(posedge clk);
        #1;
        chk((count - c) inside {[16'd9:16'd11]}, 1'b1);
        cpu_idle = 1'b0;
        i_cpu.wr(cawd_pkg::MODE_ADDR, 8'h04);
        i_cpu.idle();
        c = count;
        repeat (46) @(posedge clk);
        #1;
        chk((count - c) inside {[16'd9:16'd11]}, 1'b1);
        i_cpu.wr(cawd_pkg::CTRL_ADDR, 8'h00);
        i_cpu.idle();
    endtask
    // Main sequence
    initial begin
        fail_count = 0;
        checked = 0;
        cpu_idle = 1'b0;
        evt = 3'h0;
        do_reset();
        t_defaults();
        do_reset();
        t_force();
        t_config();
        do_reset();
        t_lock();
        t_flags();
        t_wrap();
        t_clksel();
        complete_run();
    end
endmodule
